// ---- rtl/olcs_supervisor.sv ----
// Output setpoint, limit, residual-voltage and overcurrent supervisor for one channel.
// Operation
// - New setpoints are not applied during the rise or fall ramps.
// - A setpoint change while settled slews at the programmed transition rate.
// - Margin-low selection moves the output to the margin-low setpoint.
// - ADC output under warn limit sets status bits and raises alert unless masked.
// - Undervoltage fault comes from the supervisor comparator against the fault limit.
// - Ceiling reads 14.0V in high range, 7.0V in low range.
// - Setpoint above ceiling raises CML, clamps, and sets the ceiling warning bit.
// - Ceiling is read-only, two bytes, unsigned linear format.
// - Residual voltage present when ADC output exceeds the off-threshold.
// - Threshold disabled: the PWM shuts down regardless of residual voltage.
// - Ignore bit clear: residual drives off-timeout warnings and holds off turn-on.
// - Threshold enabled: PWM runs until two samples fall to or below the threshold.
// - Threshold enabled: sample checking starts only after the fall ramp ends.
// - Threshold enabled: one low sample marks residual absent and blocks the warning.
// - Any fault turns the PWM off at once, ignoring the threshold.
// - Sense gain is scaled by one plus tempco times temperature minus 27.
// - Effective gain applies to all current quantities and both current limits.
// - Fault limit rounds up to one of eight sense levels per range; a limit above the top level takes the top level.
// - Bit 7 of the PWM mode register selects low or high current range.
// - Overcurrent fault is not evaluated during the rise or fall ramps.
// - Current limit sets status bits and raises alert unless masked.
// - Voltage mode byte holds linear mode and the exponent of voltage commands.
`timescale 1ns/10ps
`default_nettype none
`include "olcs_cfg.svh"

module olcs_supervisor (
  input  wire logic                 clk_sys,
  input  wire logic                 reset_n,
  input  wire olcs_pkg::olcs_cmd_s  cmd,
  output logic [15:0]               rdata,
  output logic                      rvalid,
  input  wire olcs_pkg::olcs_seq_e  seq_state,
  input  wire logic                 margin_low_sel,
  input  wire logic                 slew_tick,
  input  wire logic [15:0]          slew_step,
  input  wire olcs_pkg::olcs_adc_s  adc,
  input  wire logic signed [15:0]   read_temperature,
  input  wire logic                 uv_comparator,
  input  wire logic                 oc_detect,
  input  wire logic                 fault_any,
  output logic [15:0]               vout_target,
  output logic [15:0]               uv_fault_level,
  output logic [2:0]                oc_level_code,
  output logic [31:0]               gain_eff_q8,
  output logic                      pwm_enable,
  output logic                      residual_present,
  output logic                      turn_on_block,
  output logic                      off_timeout_warn_arm,
  output logic                      alert_n
);
  import olcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers written by the host.

  logic [15:0] setpoint, margin_low, uv_warn, uv_fault, off_thr;
  logic [15:0] sense_gain, oc_fault, oc_warn, tempco, alert_mask;
  logic [7:0]  pwm_mode, chan_cfg;
  logic [15:0] ceiling;
  logic        over_ceiling;

  assign ceiling = pwm_mode[`OLCS_PWM_LOW_VOUT_BIT] ? `OLCS_CEIL_LOW : `OLCS_CEIL_HIGH;
  assign over_ceiling = cmd.wr && cmd.code == `OLCS_CMD_SETPOINT && cmd.wdata > ceiling;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      setpoint   <= `OLCS_RST_SETPOINT;
      margin_low <= `OLCS_RST_MARGIN_LOW;
      uv_warn    <= `OLCS_RST_UV_WARN;
      uv_fault   <= `OLCS_RST_UV_FAULT;
      off_thr    <= `OLCS_RST_OFF_THRESHOLD;
      sense_gain <= `OLCS_RST_SENSE_GAIN;
      oc_fault   <= `OLCS_RST_OC_FAULT;
      oc_warn    <= `OLCS_RST_OC_WARN;
      tempco     <= `OLCS_RST_TEMPCO;
      alert_mask <= `OLCS_RST_ALERT_MASK;
      pwm_mode   <= `OLCS_RST_PWM_MODE;
      chan_cfg   <= `OLCS_RST_CHAN_CONFIG;
    end else if (cmd.wr) begin
      unique case (cmd.code)
        `OLCS_CMD_SETPOINT: begin
          setpoint <= over_ceiling ? ceiling : cmd.wdata;
        end
        `OLCS_CMD_MARGIN_LOW:    margin_low <= cmd.wdata;
        `OLCS_CMD_UV_WARN:       uv_warn    <= cmd.wdata;
        `OLCS_CMD_UV_FAULT:      uv_fault   <= cmd.wdata;
        `OLCS_CMD_OFF_THRESHOLD: off_thr    <= cmd.wdata;
        `OLCS_CMD_SENSE_GAIN:    sense_gain <= cmd.wdata;
        `OLCS_CMD_OC_FAULT:      oc_fault   <= cmd.wdata;
        `OLCS_CMD_OC_WARN:       oc_warn    <= cmd.wdata;
        `OLCS_CMD_TEMPCO:        tempco     <= cmd.wdata;
        `OLCS_CMD_ALERT_MASK:    alert_mask <= cmd.wdata;
        `OLCS_CMD_PWM_MODE:      pwm_mode   <= cmd.wdata[7:0];
        `OLCS_CMD_CHAN_CONFIG:   chan_cfg   <= cmd.wdata[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the analog comparators.

  logic [1:0] uv_sync, oc_sync;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      uv_sync <= 2'h0;
      oc_sync <= 2'h0;
    end else begin
      uv_sync <= {uv_sync[0], uv_comparator};
      oc_sync <= {oc_sync[0], oc_detect};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setpoint selection and slewing.

  logic [15:0] selected;

  assign selected = margin_low_sel ? margin_low : setpoint;
  assign uv_fault_level = uv_fault;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      vout_target <= `OLCS_RST_SETPOINT;
    end else begin
      unique case (seq_state)
        OLCS_SEQ_OFF: begin
          vout_target <= selected;
        end
        OLCS_SEQ_ON: begin
          if (slew_tick) begin
            if (selected > vout_target) begin
              vout_target <= (selected - vout_target > slew_step) ?
                             vout_target + slew_step : selected;
            end else if (vout_target > selected) begin
              vout_target <= (vout_target - selected > slew_step) ?
                             vout_target - slew_step : selected;
            end
          end
        end
        // The ramp engine owns the output while rising or falling, so the
        // applied value is frozen and a new command waits for steady state.
        OLCS_SEQ_RISE, OLCS_SEQ_FALL: vout_target <= vout_target;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current gain with temperature, limit scaling and quantisation.

  // Product of two linear 5s/11s words, in units times 256, clipped at zero.
  function automatic logic [39:0] l11_mul_q8(input logic [15:0] a, input logic [15:0] b);
    logic signed [21:0] prod;
    logic signed [6:0]  sh;
    logic [39:0]        mag;
    prod = $signed(a[10:0]) * $signed(b[10:0]);
    sh   = 7'(signed'(a[15:11])) + 7'(signed'(b[15:11])) + 7'sd8;
    mag  = prod < 0 ? 40'h0 : 40'(prod);
    if (sh >= 0) begin
      l11_mul_q8 = mag << sh;
    end else begin
      l11_mul_q8 = mag >> (-sh);
    end
  endfunction

  logic signed [47:0] tc_term;
  logic signed [47:0] factor_q16;
  logic [39:0]        gain_q8;
  logic [79:0]        gain_scaled;
  logic [39:0]        oc_sense_raw, ocw_sense_raw;
  logic [79:0]        oc_sense_s, ocw_sense_s;
  logic [23:0]        oc_sense_q8, ocw_sense_q8;
  logic [15:0]        one_l11;

  assign one_l11     = 16'h0001;
  assign tc_term     = 48'(signed'(tempco)) * 48'(read_temperature - `OLCS_NOMINAL_TEMP)
                       * 48'(`OLCS_PPM_Q16_SCALE);
  assign factor_q16  = 48'sh0000_0001_0000 + (tc_term >>> 16);
  assign gain_q8     = l11_mul_q8(sense_gain, one_l11);
  assign gain_scaled = (factor_q16 < 0) ? 80'h0 : (80'(gain_q8) * 80'(factor_q16)) >> 16;
  assign oc_sense_raw  = l11_mul_q8(oc_fault, sense_gain);
  assign ocw_sense_raw = l11_mul_q8(oc_warn, sense_gain);
  assign oc_sense_s  = (factor_q16 < 0) ? 80'h0 : (80'(oc_sense_raw) * 80'(factor_q16)) >> 16;
  assign ocw_sense_s = (factor_q16 < 0) ? 80'h0 : (80'(ocw_sense_raw) * 80'(factor_q16)) >> 16;
  // Limits are held in millivolts times 256 of sense voltage: amperes times milliohms.
  assign oc_sense_q8  = (oc_sense_s > 80'h00FF_FFFF) ? 24'hFF_FFFF : oc_sense_s[23:0];
  assign ocw_sense_q8 = (ocw_sense_s > 80'h00FF_FFFF) ? 24'hFF_FFFF : ocw_sense_s[23:0];

  logic [23:0] level_lo [8];
  logic [23:0] level_hi [8];
  logic [7:0]  level_ok;
  logic        high_range;

  assign level_lo = '{24'h00_1900, 24'h00_1C9A, 24'h00_201A, 24'h00_23B3,
                      24'h00_274D, 24'h00_2AE6, 24'h00_2E66, 24'h00_3200};
  assign level_hi = '{24'h00_2580, 24'h00_2AE6, 24'h00_3033, 24'h00_359A,
                      24'h00_3AE6, 24'h00_404D, 24'h00_459A, 24'h00_4B00};
  assign high_range = pwm_mode[`OLCS_PWM_HIGH_IOUT_BIT];

  for (genvar i = 0; i < 8; i++) begin : g_level
    assign level_ok[i] = (high_range ? level_hi[i] : level_lo[i]) >= oc_sense_q8;
  end

  logic [2:0] next_level;

  always_comb begin
    next_level = 3'h7;
    for (int i = 7; i >= 0; i--) begin
      if (level_ok[i]) begin
        next_level = 3'(i);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      oc_level_code <= 3'h7;
      gain_eff_q8   <= 32'h0000_0000;
    end else begin
      oc_level_code <= next_level;
      gain_eff_q8   <= (gain_scaled > 80'hFFFF_FFFF) ? 32'hFFFF_FFFF : gain_scaled[31:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Residual voltage and PWM shutdown control.

  logic       thr_en, ignore_res;
  logic       off_hold;
  logic [1:0] low_count;
  olcs_seq_e  seq_prev;
  logic       sample_low;

  assign thr_en     = chan_cfg[`OLCS_CFG_THR_EN_BIT];
  assign ignore_res = chan_cfg[`OLCS_CFG_IGNORE_BIT];
  assign sample_low = adc.valid && adc.vout <= off_thr;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      seq_prev  <= OLCS_SEQ_OFF;
      off_hold  <= 1'b0;
      low_count <= 2'h0;
    end else begin
      seq_prev <= seq_state;
      if (fault_any) begin
        off_hold  <= 1'b0;
        low_count <= 2'h0;
      end else if (seq_prev == OLCS_SEQ_FALL && seq_state == OLCS_SEQ_OFF) begin
        off_hold  <= thr_en;
        low_count <= 2'h0;
      end else if (off_hold && sample_low) begin
        if (low_count + 2'h1 >= `OLCS_OFF_SAMPLES) begin
          off_hold <= 1'b0;
        end
        low_count <= low_count + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      residual_present <= 1'b0;
    end else if (adc.valid) begin
      if (thr_en && (seq_state == OLCS_SEQ_FALL || seq_state == OLCS_SEQ_RISE)) begin
        residual_present <= residual_present;
      end else begin
        residual_present <= adc.vout > off_thr;
      end
    end
  end

  always_comb begin
    pwm_enable           = !fault_any && (seq_state != OLCS_SEQ_OFF || off_hold);
    turn_on_block        = !ignore_res && residual_present;
    off_timeout_warn_arm = !ignore_res && residual_present;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latched status and alert.

  logic [7:0] status_vout, status_iout;
  logic       cml;
  logic       clr_all, clr_vout, clr_iout;
  logic       ramping, uv_warn_evt, oc_fault_evt, oc_warn_evt;

  assign clr_all  = cmd.wr && cmd.code == `OLCS_CMD_CLEAR_FAULTS;
  assign clr_vout = cmd.wr && cmd.code == `OLCS_CMD_STATUS_VOUT;
  assign clr_iout = cmd.wr && cmd.code == `OLCS_CMD_STATUS_IOUT;
  assign ramping  = seq_state == OLCS_SEQ_RISE || seq_state == OLCS_SEQ_FALL;
  assign uv_warn_evt  = adc.valid && adc.vout < uv_warn;
  assign oc_fault_evt = oc_sync[1] && !ramping;
  assign oc_warn_evt  = adc.valid && adc.iout_sense_q8 > ocw_sense_q8;

  // Each bit is sticky; a new event in the clearing cycle keeps the bit set.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      status_vout <= 8'h00;
      status_iout <= 8'h00;
      cml         <= 1'b0;
    end else begin
      status_vout <= (clr_all ? 8'h00 : clr_vout ? status_vout & ~cmd.wdata[7:0] : status_vout)
                   | (8'(uv_warn_evt) << `OLCS_SV_UV_WARN_BIT)
                   | (8'(uv_sync[1]) << `OLCS_SV_UV_FAULT_BIT)
                   | (8'(over_ceiling) << `OLCS_SV_CEIL_WARN_BIT);
      status_iout <= (clr_all ? 8'h00 : clr_iout ? status_iout & ~cmd.wdata[7:0] : status_iout)
                   | (8'(oc_fault_evt) << `OLCS_SI_OC_FAULT_BIT)
                   | (8'(oc_warn_evt) << `OLCS_SI_OC_WARN_BIT);
      cml <= over_ceiling || (cml && !clr_all);
    end
  end

  logic [7:0]  status_byte;
  logic [15:0] status_word;

  always_comb begin
    status_byte = 8'h00;
    status_byte[`OLCS_SB_NONE_BIT] = |status_vout || |status_iout;
    status_byte[`OLCS_SB_CML_BIT]  = cml;
    status_word = {8'h00, status_byte};
    status_word[`OLCS_SW_VOUT_BIT] = |status_vout;
    status_word[`OLCS_SW_IOUT_BIT] = |status_iout;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= !(|(status_vout & ~alert_mask[7:0]) || |(status_iout & ~alert_mask[15:8])
                   || cml);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= cmd.rd;
      if (cmd.rd) begin
        unique case (cmd.code)
          `OLCS_CMD_VOLTAGE_MODE:  rdata <= {8'h00, `OLCS_RST_VOLTAGE_MODE};
          `OLCS_CMD_SETPOINT:      rdata <= setpoint;
          `OLCS_CMD_MARGIN_LOW:    rdata <= margin_low;
          `OLCS_CMD_UV_WARN:       rdata <= uv_warn;
          `OLCS_CMD_UV_FAULT:      rdata <= uv_fault;
          `OLCS_CMD_CEILING:       rdata <= ceiling;
          `OLCS_CMD_OFF_THRESHOLD: rdata <= off_thr;
          `OLCS_CMD_SENSE_GAIN:    rdata <= sense_gain;
          `OLCS_CMD_OC_FAULT:      rdata <= oc_fault;
          `OLCS_CMD_OC_WARN:       rdata <= oc_warn;
          `OLCS_CMD_TEMPCO:        rdata <= tempco;
          `OLCS_CMD_ALERT_MASK:    rdata <= alert_mask;
          `OLCS_CMD_PWM_MODE:      rdata <= {8'h00, pwm_mode};
          `OLCS_CMD_CHAN_CONFIG:   rdata <= {8'h00, chan_cfg};
          `OLCS_CMD_STATUS_BYTE:   rdata <= {8'h00, status_byte};
          `OLCS_CMD_STATUS_WORD:   rdata <= status_word;
          `OLCS_CMD_STATUS_VOUT:   rdata <= {8'h00, status_vout};
          `OLCS_CMD_STATUS_IOUT:   rdata <= {8'h00, status_iout};
          default:                 rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ---- shared/olcs_cfg.svh ----
// Command codes, field positions, reset values and fixed levels of the limit supervisor.
`ifndef OLCS_CFG_SVH
`define OLCS_CFG_SVH

`define OLCS_CMD_CLEAR_FAULTS   8'h03
`define OLCS_CMD_ALERT_MASK     8'h1B
`define OLCS_CMD_VOLTAGE_MODE   8'h20
`define OLCS_CMD_SETPOINT       8'h21
`define OLCS_CMD_MARGIN_LOW     8'h26
`define OLCS_CMD_SENSE_GAIN     8'h38
`define OLCS_CMD_UV_WARN        8'h43
`define OLCS_CMD_UV_FAULT       8'h44
`define OLCS_CMD_OC_FAULT       8'h46
`define OLCS_CMD_OC_WARN        8'h4A
`define OLCS_CMD_STATUS_BYTE    8'h78
`define OLCS_CMD_STATUS_WORD    8'h79
`define OLCS_CMD_STATUS_VOUT    8'h7A
`define OLCS_CMD_STATUS_IOUT    8'h7B
`define OLCS_CMD_CEILING        8'hA5
`define OLCS_CMD_PWM_MODE       8'hD0
`define OLCS_CMD_CHAN_CONFIG    8'hD1
`define OLCS_CMD_OFF_THRESHOLD  8'hDA
`define OLCS_CMD_TEMPCO         8'hF6

`define OLCS_RST_VOLTAGE_MODE   8'h14
`define OLCS_RST_SETPOINT       16'h1000
`define OLCS_RST_MARGIN_LOW     16'h0F33
`define OLCS_RST_UV_WARN        16'h0ECD
`define OLCS_RST_UV_FAULT       16'h0E66
`define OLCS_RST_OFF_THRESHOLD  16'h019A
`define OLCS_RST_SENSE_GAIN     16'hBB9A
`define OLCS_RST_OC_FAULT       16'hDBB8
`define OLCS_RST_OC_WARN        16'hDA80
`define OLCS_RST_TEMPCO         16'h0F3C
`define OLCS_RST_PWM_MODE       8'h00
`define OLCS_RST_CHAN_CONFIG    8'h00
`define OLCS_RST_ALERT_MASK     16'h0000

`define OLCS_CEIL_HIGH          16'hE000
`define OLCS_CEIL_LOW           16'h7000

`define OLCS_PWM_LOW_VOUT_BIT   1
`define OLCS_PWM_HIGH_IOUT_BIT  7
`define OLCS_CFG_IGNORE_BIT     0
`define OLCS_CFG_THR_EN_BIT     5

`define OLCS_SV_UV_WARN_BIT     5
`define OLCS_SV_UV_FAULT_BIT    4
`define OLCS_SV_CEIL_WARN_BIT   3
`define OLCS_SI_OC_FAULT_BIT    7
`define OLCS_SI_OC_WARN_BIT     5
`define OLCS_SB_NONE_BIT        0
`define OLCS_SB_CML_BIT         1
`define OLCS_SW_IOUT_BIT        14
`define OLCS_SW_VOUT_BIT        15

`define OLCS_NOMINAL_TEMP       16'sh001B
`define OLCS_PPM_Q16_SCALE      32'sh0000_10C7
`define OLCS_OFF_SAMPLES        2'h2

`endif

// ---- shared/olcs_pkg.sv ----
// Types shared by the limit supervisor and its surroundings.
package olcs_pkg;

  typedef enum logic [1:0] {
    OLCS_SEQ_OFF,
    OLCS_SEQ_RISE,
    OLCS_SEQ_ON,
    OLCS_SEQ_FALL
  } olcs_seq_e;

  typedef struct packed {
    logic [7:0]  code;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } olcs_cmd_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] vout;
    logic [23:0] iout_sense_q8;
  } olcs_adc_s;

endpackage

// ---- testbench/olcs_checker.sv ----
// Port-level assertions for the limit supervisor, bound onto its top module.
`timescale 1ns/10ps
`default_nettype none
`include "olcs_cfg.svh"
module olcs_checker (
  input wire logic                clk_sys,
  input wire logic                reset_n,
  input wire olcs_pkg::olcs_cmd_s cmd,
  input wire logic [15:0]         rdata,
  input wire logic                rvalid,
  input wire olcs_pkg::olcs_seq_e seq_state,
  input wire logic                slew_tick,
  input wire logic                fault_any,
  input wire logic [15:0]         vout_target,
  input wire logic [15:0]         uv_fault_level,
  input wire logic                pwm_enable,
  input wire logic                residual_present,
  input wire logic                turn_on_block,
  input wire logic                off_timeout_warn_arm,
  input wire logic                alert_n
);
  import olcs_pkg::*;
  logic        low_range;
  logic        thr_en;
  logic        ign;
  logic [15:0] ceiling;
  // Configuration bits are rebuilt from the write stream, as the checker sees only ports.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      low_range <= 1'b0;
    end else if (cmd.wr && cmd.code == `OLCS_CMD_PWM_MODE) begin
      low_range <= cmd.wdata[1];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      thr_en <= 1'b0;
      ign    <= 1'b0;
    end else if (cmd.wr && cmd.code == `OLCS_CMD_CHAN_CONFIG) begin
      thr_en <= cmd.wdata[5];
      ign    <= cmd.wdata[0];
    end
  end
  assign ceiling = low_range ? 16'h7000 : 16'he000;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_ceil; cmd.rd && cmd.code == 8'ha5 |=> rvalid && rdata == ceiling; endproperty
  a_ceil: assert property (p_ceil) else $error("ceiling read wrong");
  property p_uv_lvl; cmd.wr && cmd.code == 8'h44 |=> uv_fault_level == $past(cmd.wdata); endproperty
  a_uv_lvl: assert property (p_uv_lvl) else $error("uv level not applied");
  property p_ramp; seq_state inside {OLCS_SEQ_RISE, OLCS_SEQ_FALL} |=> $stable(vout_target); endproperty
  a_ramp: assert property (p_ramp) else $error("target moved in ramp");
  property p_slew; seq_state == OLCS_SEQ_ON && !slew_tick |=> $stable(vout_target); endproperty
  a_slew: assert property (p_slew) else $error("target moved without tick");
  property p_clamp; cmd.wr && cmd.code == 8'h21 && cmd.wdata > ceiling |-> ##2 !alert_n; endproperty
  a_clamp: assert property (p_clamp) else $error("no alert on clamp");
  property p_fault; fault_any |-> !pwm_enable; endproperty
  a_fault: assert property (p_fault) else $error("pwm on in fault");
  property p_thr_off; seq_state == OLCS_SEQ_OFF && !thr_en |-> !pwm_enable; endproperty
  a_thr_off: assert property (p_thr_off) else $error("pwm held with threshold off");
  property p_block; turn_on_block == (!ign && residual_present) && off_timeout_warn_arm == turn_on_block;
  endproperty
  a_block: assert property (p_block) else $error("turn-on block wrong");
  c_ceil_low: cover property (cmd.rd && cmd.code == 8'ha5 && low_range);
  c_fault: cover property (fault_any && seq_state == OLCS_SEQ_OFF);
  c_alert: cover property (!alert_n);
endmodule
bind olcs_supervisor olcs_checker u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .cmd(cmd),
  .rdata(rdata), .rvalid(rvalid), .seq_state(seq_state), .slew_tick(slew_tick),
  .fault_any(fault_any), .vout_target(vout_target), .uv_fault_level(uv_fault_level),
  .pwm_enable(pwm_enable), .residual_present(residual_present), .turn_on_block(turn_on_block),
  .off_timeout_warn_arm(off_timeout_warn_arm), .alert_n(alert_n));
`default_nettype wire

// ---- testbench/olcs_plant_model.sv ----
// Rail stand-in: output converter samples and the undervoltage comparator.
`timescale 1ns/10ps
`default_nettype none
module olcs_plant_model (
  input  wire logic           clk_sys,
  input  wire logic           reset_n,
  input  wire logic [15:0]    level,
  input  wire logic           sample,
  input  wire logic [15:0]    uv_fault_level,
  output olcs_pkg::olcs_adc_s adc,
  output logic                uv_comparator
);
  import olcs_pkg::*;
  // Between conversions the value field flips every cycle, so a stale sample never looks fresh.
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      adc <= '0;
    end else begin
      adc.valid         <= sample;
      adc.vout          <= sample ? level : ~adc.vout;
      adc.iout_sense_q8 <= 24'h00_0000;
    end
  end
  // The comparator watches the rail directly, with no converter in the path.
  assign uv_comparator = level < uv_fault_level;
endmodule
`default_nettype wire

// ---- testbench/olcs_supervisor_tb_top.sv ----
// Directed testbench for the limit supervisor.
`timescale 1ns/10ps
`default_nettype none
module olcs_supervisor_tb_top;
  import olcs_pkg::*;
  logic               clk_sys, reset_n, rvalid, margin_low_sel, slew_tick, uv_comparator;
  logic               oc_detect, fault_any, pwm_enable, residual_present, turn_on_block;
  logic               alert_n, sample;
  logic [15:0]        rdata, slew_step, vout_target, uv_fault_level, level;
  logic [2:0]         oc_level_code;
  logic [31:0]        gain_eff_q8;
  logic signed [15:0] read_temperature;
  olcs_cmd_s          cmd;
  olcs_seq_e          seq_state;
  olcs_adc_s          adc;
  int                 err_count, n_tests, i;
  logic [7:0]         rcode [12] = '{8'h20, 8'h21, 8'h26, 8'h43, 8'h44, 8'hda, 8'h38, 8'h46,
                                     8'h4a, 8'hf6, 8'ha5, 8'h7a};
  logic [15:0]        rval [12] = '{16'h0014, 16'h1000, 16'h0f33, 16'h0ecd, 16'h0e66, 16'h019a,
                                    16'hbb9a, 16'hdbb8, 16'hda80, 16'h0f3c, 16'he000, 16'h0000};
  olcs_supervisor dut (.clk_sys(clk_sys), .reset_n(reset_n), .cmd(cmd), .rdata(rdata),
    .rvalid(rvalid), .seq_state(seq_state), .margin_low_sel(margin_low_sel),
    .slew_tick(slew_tick), .slew_step(slew_step), .adc(adc), .read_temperature(read_temperature),
    .uv_comparator(uv_comparator), .oc_detect(oc_detect), .fault_any(fault_any),
    .vout_target(vout_target), .uv_fault_level(uv_fault_level), .oc_level_code(oc_level_code),
    .gain_eff_q8(gain_eff_q8), .pwm_enable(pwm_enable), .residual_present(residual_present),
    .turn_on_block(turn_on_block), .off_timeout_warn_arm(), .alert_n(alert_n));
  olcs_plant_model plant (.clk_sys(clk_sys), .reset_n(reset_n), .level(level), .sample(sample),
    .uv_fault_level(uv_fault_level), .adc(adc), .uv_comparator(uv_comparator));
  always #50 clk_sys = ~clk_sys;
  task automatic conclude();
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    cmd.code = c;
    cmd.wdata = v;
    cmd.wr = 1'b1;
    tick(1);
    cmd.wr = 1'b0;
    tick(1);
  endtask
  // Reads a register and compares the bits under the mask.
  task automatic rc(input logic [7:0] c, input logic [15:0] m, input logic [15:0] e);
    cmd.code = c;
    cmd.rd = 1'b1;
    tick(1);
    cmd.rd = 1'b0;
    for (int k = 0; k < 3 && rvalid !== 1'b1; k++) tick(1);
    if (rvalid !== 1'b1) begin
      err_count++;
      conclude();
    end
    chk($sformatf("reg_%h", c), {16'h0000, e}, {16'h0000, rdata & m});
    tick(1);
  endtask
  task automatic smp(input logic [15:0] v);
    level = v;
    sample = 1'b1;
    tick(1);
    sample = 1'b0;
    tick(4);
  endtask
  task automatic slew(input int n);
    repeat (n) begin
      slew_tick = 1'b1;
      tick(1);
      slew_tick = 1'b0;
      tick(1);
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    conclude();
  end
  initial begin
    {clk_sys, reset_n, margin_low_sel, slew_tick, oc_detect, fault_any, sample} = '0;
    cmd = '0;
    seq_state = OLCS_SEQ_OFF;
    slew_step = 16'h0100;
    read_temperature = 16'sh0025;
    level = 16'h1000;
    tick(20);
    reset_n = 1'b1;
    tick(1);
    chk("alert_n", 1, alert_n);
    for (i = 0; i < 12; i++) rc(rcode[i], 16'hffff, rval[i]);
    wr(8'ha5, 16'h1234);
    rc(8'ha5, 16'hffff, 16'he000);
    wr(8'hd0, 16'h0002);
    rc(8'ha5, 16'hffff, 16'h7000);
    wr(8'h21, 16'h8000);
    rc(8'h21, 16'hffff, 16'h7000);
    chk("alert_n", 0, alert_n);
    chk("vout_target", 16'h7000, vout_target);
    rc(8'h7a, 16'h0008, 16'h0008);
    rc(8'h78, 16'h0002, 16'h0002);
    wr(8'h03, 16'h0000);
    tick(2);
    chk("alert_n", 1, alert_n);
    rc(8'h7a, 16'hffff, 16'h0000);
    wr(8'hd0, 16'h0000);
    wr(8'h21, 16'h1000);
    wr(8'h26, 16'h0c00);
    margin_low_sel = 1'b1;
    tick(2);
    chk("vout_target", 16'h0c00, vout_target);
    margin_low_sel = 1'b0;
    tick(2);
    seq_state = OLCS_SEQ_RISE;
    wr(8'h21, 16'h0c00);
    tick(2);
    chk("vout_target", 16'h1000, vout_target);
    seq_state = OLCS_SEQ_ON;
    tick(3);
    chk("vout_target", 16'h1000, vout_target);
    slew(1);
    chk("vout_target", 16'h0f00, vout_target);
    slew(4);
    chk("vout_target", 16'h0c00, vout_target);
    wr(8'h44, 16'h0400);
    chk("uv_fault_level", 16'h0400, uv_fault_level);
    wr(8'h1b, 16'h0020);
    smp(16'h0800);
    chk("alert_n", 1, alert_n);
    rc(8'h7a, 16'hffff, 16'h0020);
    rc(8'h79, 16'h8000, 16'h8000);
    rc(8'h78, 16'h0001, 16'h0001);
    wr(8'h1b, 16'h0000);
    tick(2);
    chk("alert_n", 0, alert_n);
    wr(8'h7a, 16'h0020);
    tick(2);
    chk("alert_n", 1, alert_n);
    smp(16'h0300);
    rc(8'h7a, 16'h0010, 16'h0010);
    level = 16'h1000;
    wr(8'h03, 16'h0000);
    seq_state = OLCS_SEQ_RISE;
    oc_detect = 1'b1;
    tick(4);
    rc(8'h7b, 16'hffff, 16'h0000);
    seq_state = OLCS_SEQ_ON;
    tick(4);
    rc(8'h7b, 16'h0080, 16'h0080);
    rc(8'h79, 16'h4000, 16'h4000);
    oc_detect = 1'b0;
    wr(8'h03, 16'h0000);
    chk("gain_eff_q8", 32'h0000_01de, gain_eff_q8);
    wr(8'hd0, 16'h0080);
    tick(3);
    chk("oc_level_code", 4, oc_level_code);
    wr(8'hd0, 16'h0000);
    wr(8'h46, 16'h000e);
    tick(3);
    chk("oc_level_code", 1, oc_level_code);
    wr(8'h46, 16'h000a);
    tick(3);
    chk("oc_level_code", 0, oc_level_code);
    wr(8'h43, 16'h0000);
    wr(8'h44, 16'h0000);
    wr(8'hda, 16'h0200);
    wr(8'hd1, 16'h0020);
    smp(16'h0800);
    chk("residual_present", 1, residual_present);
    chk("turn_on_block", 1, turn_on_block);
    seq_state = OLCS_SEQ_FALL;
    smp(16'h0100);
    seq_state = OLCS_SEQ_OFF;
    tick(2);
    chk("pwm_enable", 1, pwm_enable);
    smp(16'h0100);
    chk("residual_present", 0, residual_present);
    chk("pwm_enable", 1, pwm_enable);
    smp(16'h0100);
    chk("pwm_enable", 0, pwm_enable);
    seq_state = OLCS_SEQ_ON;
    smp(16'h0800);
    seq_state = OLCS_SEQ_FALL;
    tick(2);
    seq_state = OLCS_SEQ_OFF;
    tick(2);
    fault_any = 1'b1;
    tick(1);
    chk("pwm_enable", 0, pwm_enable);
    fault_any = 1'b0;
    wr(8'hd1, 16'h0001);
    chk("pwm_enable", 0, pwm_enable);
    chk("turn_on_block", 0, turn_on_block);
    conclude();
  end
endmodule
`default_nettype wire
